// File: fieldbus_pkg.sv
/*
 Constants, frame codes and the check-field arithmetic used by the slave
 query handler; its transmit buffer uses none of them. Assumes one 20 MHz clock domain.
*/
// Notes on behaviour
// - Single write lands at holding register number offset plus 40001.
// - Single write data is two bytes, high byte then low byte.
// - Slave address 0 is a broadcast; both write functions still execute.
// - Unicast single write answers with a copy of the query; broadcast answers nothing.
// - Diagnostic subfunction 0000 echoes the query back unchanged.
// - The diagnostic data field may hold any 16-bit value.
// - Diagnostic queries sent to address 0 are invalid and ignored.
// - Multiple write fields: address, 10h, start, count, byte count, data, check.
// - Multiple write addresses at most 125 registers; larger counts are invalid.
// - Byte count equals twice the register count, within 2 to 250.
// - Data words arrive high byte first, stored at start then ascending registers.
// - Multiple write start field is holding register number minus 40001.
// - Single writes only reach environment and drive parameter areas.
// - Check field goes low byte first; a mismatch is an error.
// - No answer to frames with parity, check, overrun, framing or busy errors.
package fieldbus_pkg;

	localparam logic [7:0] FN_WRITE_ONE = 8'h06;
	localparam logic [7:0] FN_DIAG = 8'h08;
	localparam logic [7:0] FN_WRITE_MANY = 8'h10;
	localparam logic [15:0] SUB_ECHO = 16'h0000;
	localparam logic [7:0] BCAST_ADDR = 8'h00;
	localparam logic [16:0] HOLD_BASE = 17'h0_9c41;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;
	localparam logic [8:0] ONE_LEN = 9'h008;
	localparam logic [8:0] MANY_OVERHEAD = 9'h009;
	localparam logic [8:0] MANY_DATA_POS = 9'h007;
	localparam logic [8:0] MIN_LEN = 9'h004;
	localparam logic [7:0] BC_MIN = 8'h02;
	localparam logic [7:0] BC_MAX = 8'hfa;
	localparam logic [2:0] HDR_LAST = 3'h5;
	localparam int MAX_REGS = 125;
	localparam int FRAME_MAX = 260;
	localparam logic [15:0] ENV_FIRST = 16'h0000;
	localparam logic [15:0] ENV_LAST = 16'h00ff;
	localparam logic [15:0] PAR_FIRST = 16'h03e8;
	localparam logic [15:0] PAR_LAST = 16'h0fff;

	typedef enum logic [2:0] {
		ST_RX,
		ST_CHECK,
		ST_WRITE,
		ST_SEND,
		ST_CRC_LO,
		ST_CRC_HI
	} state_type;

	// One byte through the check-field register, bit 0 first
	function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

endpackage

// File: byte_skid2.sv
/*
 Two-entry buffer with valid and ready on both sides, registered outputs.
 Assumes a reset already synchronised to clock and a same-domain drain.
*/
`timescale 1ns/1ps
module byte_skid2 #(
	parameter int WIDTH = 8
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready
);
	logic [WIDTH-1:0] slot1_r;
	logic [1:0] cnt_r;
	logic push;
	logic pop;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("byte_skid2 needs a positive width");
		end
	endgenerate

	// Handshakes; full only at two words
	assign in_ready = (cnt_r != 2'h2);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Head slot feeds the port directly, second slot catches a stall
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 2'h0;
			out_valid <= 1'b0;
			out_data <= '0;
			slot1_r <= '0;
		end else if (ce) begin
			case ({push, pop})
				2'b10: begin
					if (cnt_r == 2'h0) out_data <= in_data;
					else slot1_r <= in_data;
					cnt_r <= cnt_r + 2'h1;
					out_valid <= 1'b1;
				end
				2'b01: begin
					out_data <= slot1_r;
					cnt_r <= cnt_r - 2'h1;
					out_valid <= (cnt_r == 2'h2);
				end
				2'b11: begin
					if (cnt_r == 2'h1) begin
						out_data <= in_data;
					end else begin
						out_data <= slot1_r;
						slot1_r <= in_data;
					end
				end
				default: begin
				end
			endcase
		end
	end
endmodule // byte_skid2

// File: fieldbus_slave.sv
/*
 Query handler of a serial field-bus slave: single write, diagnostic echo
 and multiple write. Assumes a byte receiver on the same clock that marks
 bytes, line errors and the inter-frame silence, and a transmitter that
 takes answer bytes with valid/ready. Register writes leave as pulses.
*/
`timescale 1ns/1ps
module fieldbus_slave #(
	parameter int FRAME_MAX = fieldbus_pkg::FRAME_MAX,
	parameter int MAX_REGS = fieldbus_pkg::MAX_REGS,
	parameter logic [15:0] ENV_FIRST = fieldbus_pkg::ENV_FIRST,
	parameter logic [15:0] ENV_LAST = fieldbus_pkg::ENV_LAST,
	parameter logic [15:0] PAR_FIRST = fieldbus_pkg::PAR_FIRST,
	parameter logic [15:0] PAR_LAST = fieldbus_pkg::PAR_LAST
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [7:0] own_addr,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_err,
	input wire logic rx_end,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	output logic wr_valid,
	output logic [16:0] wr_num,
	output logic [15:0] wr_data,
	output logic busy
);
	logic rst_meta_r;
	logic rst_sync_r;
	fieldbus_pkg::state_type st_r, st_nxt;
	logic [8:0] len_r, len_nxt;
	logic [15:0] crc_r, crc_nxt;
	logic bad_r, bad_nxt;
	logic [6:0] widx_r, widx_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic wr_valid_nxt;
	logic [16:0] wr_num_nxt;
	logic [15:0] wr_data_nxt;
	logic [7:0] frame_mem [0:FRAME_MAX-1];
	logic in_valid;
	logic in_ready;
	logic [7:0] in_data;

	generate
		if (FRAME_MAX < 259 || FRAME_MAX > 511) begin : g_bad_frame
			$error("FRAME_MAX must hold 259 bytes and fit a 9-bit length");
		end
		if (MAX_REGS < 1 || MAX_REGS > 125) begin : g_bad_regs
			$error("MAX_REGS must lie in 1 to 125");
		end
	endgenerate

	// Reset release through two flops, assertion stays asynchronous
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_r <= 1'b0;
			rst_sync_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_sync_r <= rst_meta_r;
		end
	end

	// Frame fields, always read from the stored copy
	wire [7:0] f_addr = frame_mem[0];
	wire [7:0] f_fn = frame_mem[1];
	wire [15:0] f_w2 = {frame_mem[2], frame_mem[3]};
	wire [15:0] f_w4 = {frame_mem[4], frame_mem[5]};
	wire [7:0] f_bc = frame_mem[6];
	wire store_ok = (len_r < 9'(FRAME_MAX));

	wire is_bcast = (f_addr == fieldbus_pkg::BCAST_ADDR);
	wire is_mine = (f_addr == own_addr) && (own_addr != fieldbus_pkg::BCAST_ADDR);
	wire addressed = is_bcast || is_mine;
	// residue over data plus check field is zero when intact
	wire crc_good = (crc_r == 16'h0000);
	// line or busy errors silence the frame
	wire frame_ok = !bad_r && crc_good && addressed;

	// writable areas for the single write
	wire one_allowed = ((f_w2 >= ENV_FIRST) && (f_w2 <= ENV_LAST)) ||
		((f_w2 >= PAR_FIRST) && (f_w2 <= PAR_LAST));
	// fixed eight-byte frame, two data bytes
	wire ok_one = (f_fn == fieldbus_pkg::FN_WRITE_ONE) && (len_r == fieldbus_pkg::ONE_LEN) &&
		one_allowed;
	// no diagnostic by broadcast; data field unchecked
	wire ok_diag = (f_fn == fieldbus_pkg::FN_DIAG) && (len_r == fieldbus_pkg::ONE_LEN) &&
		(f_w2 == fieldbus_pkg::SUB_ECHO) && !is_bcast;
	wire count_ok = (f_w4 != 16'h0000) && (f_w4 <= 16'(MAX_REGS));
	wire bc_ok = (f_bc >= fieldbus_pkg::BC_MIN) && (f_bc <= fieldbus_pkg::BC_MAX) &&
		({8'h00, f_bc} == {f_w4[14:0], 1'b0});
	// field layout fixes the whole length
	wire ok_many = (f_fn == fieldbus_pkg::FN_WRITE_MANY) && count_ok && bc_ok &&
		(len_r == fieldbus_pkg::MANY_OVERHEAD + {1'b0, f_bc});

	wire [8:0] word_pos = fieldbus_pkg::MANY_DATA_POS + {1'b0, widx_r, 1'b0};
	wire [15:0] many_word = {frame_mem[word_pos], frame_mem[word_pos + 9'h001]};
	wire [6:0] last_widx = (f_fn == fieldbus_pkg::FN_WRITE_MANY) ? (f_w4[6:0] - 7'h01) : 7'h00;
	wire [16:0] reg_num = {1'b0, f_w2} + fieldbus_pkg::HOLD_BASE + {10'h000, widx_r};

	// Answer bytes: header from the stored query, then a fresh check field
	assign in_valid = (st_r == fieldbus_pkg::ST_SEND) || (st_r == fieldbus_pkg::ST_CRC_LO) ||
		(st_r == fieldbus_pkg::ST_CRC_HI);
	// low byte of check field first
	assign in_data = (st_r == fieldbus_pkg::ST_SEND) ? frame_mem[{6'h00, idx_r}] :
		(st_r == fieldbus_pkg::ST_CRC_LO) ? crc_r[7:0] : crc_r[15:8];

	// Sequencer; bytes seen while busy spoil the frame they belong to
	always_comb begin
		st_nxt = st_r;
		len_nxt = len_r;
		crc_nxt = crc_r;
		bad_nxt = bad_r;
		widx_nxt = widx_r;
		idx_nxt = idx_r;
		wr_valid_nxt = 1'b0;
		wr_num_nxt = wr_num;
		wr_data_nxt = wr_data;
		if (st_r != fieldbus_pkg::ST_RX) begin
			bad_nxt = (st_r == fieldbus_pkg::ST_CHECK) ? 1'b0 : bad_r;
			if (rx_end) bad_nxt = 1'b0;
			else if (rx_valid || rx_err) bad_nxt = 1'b1;
		end
		case (st_r)
			fieldbus_pkg::ST_RX: begin
				if (rx_valid) begin
					// running check over every stored byte; a byte past the store marks the frame bad
					if (store_ok) begin
						len_nxt = len_r + 9'h001;
						crc_nxt = fieldbus_pkg::crc16_byte(crc_r, rx_data);
					end else begin
						bad_nxt = 1'b1;
					end
				end
				if (rx_err) bad_nxt = 1'b1;
				if (rx_end) begin
					if (len_r >= fieldbus_pkg::MIN_LEN) begin
						st_nxt = fieldbus_pkg::ST_CHECK;
					end else begin
						len_nxt = 9'h000;
						crc_nxt = fieldbus_pkg::CRC_INIT;
						bad_nxt = 1'b0;
					end
				end
			end
			fieldbus_pkg::ST_CHECK: begin
				crc_nxt = fieldbus_pkg::CRC_INIT;
				widx_nxt = 7'h00;
				idx_nxt = 3'h0;
				if (frame_ok && (ok_one || ok_many)) begin
					st_nxt = fieldbus_pkg::ST_WRITE;
				end else if (frame_ok && ok_diag) begin
					st_nxt = fieldbus_pkg::ST_SEND;
				end else begin
					st_nxt = fieldbus_pkg::ST_RX;
					len_nxt = 9'h000;
				end
			end
			fieldbus_pkg::ST_WRITE: begin
				// one word per cycle, ascending registers
				wr_valid_nxt = 1'b1;
				wr_num_nxt = reg_num;
				wr_data_nxt = (f_fn == fieldbus_pkg::FN_WRITE_MANY) ? many_word : f_w4;
				if (widx_r == last_widx) begin
					st_nxt = is_bcast ? fieldbus_pkg::ST_RX : fieldbus_pkg::ST_SEND;
					len_nxt = 9'h000;
				end else begin
					widx_nxt = widx_r + 7'h01;
				end
			end
			fieldbus_pkg::ST_SEND: begin
				if (in_ready) begin
					crc_nxt = fieldbus_pkg::crc16_byte(crc_r, in_data);
					if (idx_r == fieldbus_pkg::HDR_LAST) st_nxt = fieldbus_pkg::ST_CRC_LO;
					else idx_nxt = idx_r + 3'h1;
				end
			end
			fieldbus_pkg::ST_CRC_LO: begin
				if (in_ready) st_nxt = fieldbus_pkg::ST_CRC_HI;
			end
			fieldbus_pkg::ST_CRC_HI: begin
				if (in_ready) begin
					st_nxt = fieldbus_pkg::ST_RX;
					crc_nxt = fieldbus_pkg::CRC_INIT;
					len_nxt = 9'h000;
				end
			end
			default: begin
				st_nxt = fieldbus_pkg::ST_RX;
				len_nxt = 9'h000;
				crc_nxt = fieldbus_pkg::CRC_INIT;
			end
		endcase
	end

	// State registers, frozen while ce is low
	always_ff @(posedge clock or negedge rst_sync_r) begin
		if (!rst_sync_r) begin
			st_r <= fieldbus_pkg::ST_RX;
			len_r <= 9'h000;
			crc_r <= fieldbus_pkg::CRC_INIT;
			bad_r <= 1'b0;
			widx_r <= 7'h00;
			idx_r <= 3'h0;
			wr_valid <= 1'b0;
			wr_num <= 17'h0_0000;
			wr_data <= 16'h0000;
			busy <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt;
			len_r <= len_nxt;
			crc_r <= crc_nxt;
			bad_r <= bad_nxt;
			widx_r <= widx_nxt;
			idx_r <= idx_nxt;
			wr_valid <= wr_valid_nxt;
			wr_num <= wr_num_nxt;
			wr_data <= wr_data_nxt;
			busy <= (st_nxt != fieldbus_pkg::ST_RX);
		end
	end

	// Frame store; no reset so it maps to plain memory
	always_ff @(posedge clock) begin
		if (ce && (st_r == fieldbus_pkg::ST_RX) && rx_valid && store_ok) begin
			frame_mem[len_r] <= rx_data;
		end
	end

	// Answer path buffer: a stalled transmitter back-pressures ST_SEND
	byte_skid2 #(
		.WIDTH(8)
	) u_tx_buf (
		.clock(clock),
		.rst_n(rst_sync_r),
		.ce(ce),
		.in_valid(in_valid),
		.in_data(in_data),
		.in_ready(in_ready),
		.out_valid(tx_valid),
		.out_data(tx_data),
		.out_ready(tx_ready)
	);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_sync_r);

	wire at_check = (st_r == fieldbus_pkg::ST_CHECK) && ce;

	sequence s_lo_sent;
		(st_r == fieldbus_pkg::ST_CRC_LO) && in_ready && ce;
	endsequence
	sequence s_hi_next;
		(st_r == fieldbus_pkg::ST_CRC_HI) && (in_data == $past(crc_r[15:8]));
	endsequence

	a_bad_frame_silent: assert property (at_check && bad_r |=> st_r == fieldbus_pkg::ST_RX)
		else $error("errored frame was acted on");
	a_foreign_ignored: assert property (at_check && !is_mine && !is_bcast |=>
		st_r == fieldbus_pkg::ST_RX) else $error("foreign frame was acted on");
	a_diag_no_bcast: assert property (at_check && is_bcast && f_fn == fieldbus_pkg::FN_DIAG
		|=> st_r == fieldbus_pkg::ST_RX) else $error("broadcast diagnostic was acted on");
	a_count_limit: assert property (at_check && f_fn == fieldbus_pkg::FN_WRITE_MANY &&
		f_w4 > 16'(MAX_REGS) |=> st_r == fieldbus_pkg::ST_RX)
		else $error("oversized count was accepted");
	a_bcast_no_tx: assert property ((st_r == fieldbus_pkg::ST_WRITE) && ce && is_bcast &&
		widx_r == last_widx |=> st_r == fieldbus_pkg::ST_RX) else $error("broadcast answered");
	a_bcast_writes: assert property (at_check && frame_ok && is_bcast && ok_one |=>
		##1 wr_valid && wr_data == $past(f_w4, 2)) else $error("broadcast write lost");
	a_one_number: assert property (at_check && frame_ok && ok_one |=> ##1
		wr_num == {1'b0, $past(f_w2, 2)} + 17'h0_9c41) else $error("single write misplaced");
	a_many_ascend: assert property (wr_valid && $past(wr_valid) && $past(ce) &&
		f_fn == fieldbus_pkg::FN_WRITE_MANY |-> wr_num == $past(wr_num) + 17'h0_0001)
		else $error("multiple write not ascending");
	a_crc_order: assert property (s_lo_sent |=> s_hi_next)
		else $error("check field bytes out of order");
	a_bc_pairing: assert property (at_check && f_fn == fieldbus_pkg::FN_WRITE_MANY &&
		{8'h00, f_bc} != {f_w4[14:0], 1'b0} |=> st_r == fieldbus_pkg::ST_RX)
		else $error("bad byte count accepted");
endmodule // fieldbus_slave

// File: master_model.sv
/*
 Far-side model: bus master that sends query bytes and takes answer bytes.
 Assumes the slave's clock and a slave already out of reset.
*/
`timescale 1ns/1ps
module master_model (
	input wire logic clock,
	input wire logic slow,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic rx_err,
	output logic rx_end,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	input wire logic wr_valid,
	input wire logic [16:0] wr_num,
	input wire logic [15:0] wr_data
);
	logic [7:0] txq[$];
	logic [32:0] wrq[$];
	logic [2:0] tick_r = 3'h0;
	// Quiet line at start
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		rx_err = 1'b0;
		rx_end = 1'b0;
		tx_ready = 1'b0;
	end
	// Slow mode takes one byte in eight, so the buffer fills
	always @(posedge clock) begin
		tick_r <= tick_r + 3'h1;
		tx_ready <= !slow || tick_r == 3'h0;
		if (tx_valid && tx_ready)
			txq.push_back(tx_data);
		if (wr_valid)
			wrq.push_back({wr_num, wr_data});
	end
	function automatic logic [15:0] crc16(input logic [7:0] q[$]);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i]) begin
			c = c ^ {8'h00, q[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
		end
		return c;
	endfunction
	// fields as given, check low byte first
	task automatic send(input logic [7:0] f[$], input logic bad, input logic err);
		logic [15:0] c;
		c = crc16(f) ^ {15'h0000, bad};
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		foreach (f[i]) begin
			@(posedge clock);
			rx_valid <= 1'b1;
			rx_data <= f[i];
		end
		@(posedge clock);
		rx_valid <= 1'b0;
		rx_data <= ~f[f.size()-1];
		rx_err <= err;
		@(posedge clock);
		rx_err <= 1'b0;
		rx_end <= 1'b1;
		@(posedge clock);
		rx_end <= 1'b0;
	endtask
endmodule // master_model

// File: fieldbus_slave_bench.sv
/*
 Self-checking bench of the query handler with the master model.
 Assumes the design files and the model are compiled first.
*/
`timescale 1ns/1ps
module fieldbus_slave_bench;
	typedef logic [7:0] bytes_type[$];
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic slow = 1'b0;
	logic ce = 1'b1;
	int freeze = 0;
	logic [7:0] own_addr = 8'h05;
	logic rx_valid, rx_err, rx_end, tx_valid, tx_ready, wr_valid, busy;
	logic [7:0] rx_data, tx_data;
	logic [16:0] wr_num;
	logic [15:0] wr_data;
	int err_count = 0;
	int n_compared = 0;
	bytes_type none;
	logic [32:0] nowr[$];
	// 20 MHz clock
	initial begin
		forever #25 clock = ~clock;
	end
	fieldbus_slave dut_u (.clock(clock), .rst_n(rst_n), .ce(ce), .own_addr(own_addr),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err), .rx_end(rx_end),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .wr_valid(wr_valid),
		.wr_num(wr_num), .wr_data(wr_data), .busy(busy));
	master_model pm_u (.clock(clock), .slow(slow), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_err(rx_err), .rx_end(rx_end), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .wr_valid(wr_valid), .wr_num(wr_num), .wr_data(wr_data));
	task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic bytes_type with_crc(input bytes_type f);
		logic [15:0] c;
		c = pm_u.crc16(f);
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		return f;
	endfunction
	task automatic setup(input logic [7:0] a, input logic s);
		@(posedge clock);
		own_addr <= a;
		slow <= s;
	endtask
	// One frame out, wait for idle, then compare answer and writes
	task automatic run(input bytes_type f, input logic bad, input logic err,
		input bytes_type etx, input logic [32:0] ewr[$]);
		pm_u.txq.delete();
		pm_u.wrq.delete();
		pm_u.send(f, bad, err);
		// Optional freeze: with ce low nothing may be written or dropped
		if (freeze > 0) begin
			ce <= 1'b0;
			repeat (freeze) @(negedge clock);
			check("frozen busy", 33'h1, 33'(busy));
			check("frozen writes", 33'h0, 33'(pm_u.wrq.size()));
			@(posedge clock);
			ce <= 1'b1;
			freeze = 0;
		end
		// wait out processing before the next query
		for (int i = 0; i < 4000; i++) begin
			@(negedge clock);
			if (i > 4 && busy === 1'b0)
				break;
		end
		check("busy at end", 33'h0, 33'(busy));
		repeat (40) @(negedge clock);
		check("tx count", 33'(etx.size()), 33'(pm_u.txq.size()));
		foreach (etx[i])
			if (i < pm_u.txq.size())
				check("tx byte", 33'(etx[i]), 33'(pm_u.txq[i]));
		check("wr count", 33'(ewr.size()), 33'(pm_u.wrq.size()));
		foreach (ewr[i])
			if (i < pm_u.wrq.size())
				check("wr word", ewr[i], pm_u.wrq[i]);
	endtask
	task automatic t_single();
		bytes_type f;
		f = '{8'h05, 8'h06, 8'h00, 8'h0d, 8'h17, 8'h70};
		setup(8'h05, 1'b0);
		freeze = 20;
		run(f, 1'b0, 1'b0, with_crc(f), '{{17'h0_9c4e, 16'h1770}});
		// Parameter area is the second writable window
		f = '{8'h05, 8'h06, 8'h03, 8'he8, 8'h00, 8'h05};
		run(f, 1'b0, 1'b0, with_crc(f), '{{17'h0_a029, 16'h0005}});
		f = '{8'h00, 8'h06, 8'h00, 8'h0d, 8'h12, 8'h34};
		run(f, 1'b0, 1'b0, none, '{{17'h0_9c4e, 16'h1234}});
	endtask
	task automatic t_diag();
		bytes_type f;
		logic [15:0] d[3];
		d = '{16'h0000, 16'hffff, 16'ha55a};
		setup(8'h05, 1'b1);
		foreach (d[i]) begin
			f = '{8'h05, 8'h08, 8'h00, 8'h00, d[i][15:8], d[i][7:0]};
			run(f, 1'b0, 1'b0, with_crc(f), nowr);
		end
		f = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h12, 8'h34};
		run(f, 1'b0, 1'b0, none, nowr);
	endtask
	task automatic t_multi();
		bytes_type f;
		f = '{8'h19, 8'h10, 8'h03, 8'hee, 8'h00, 8'h02, 8'h04, 8'h00, 8'h05, 8'h00, 8'h0a};
		setup(8'h19, 1'b1);
		check("query crc", 33'(pm_u.crc16(f)), 33'h0_0000_3d86);
		run(f, 1'b0, 1'b0, '{8'h19, 8'h10, 8'h03, 8'hee, 8'h00, 8'h02, 8'h22, 8'h61},
			'{{17'h0_a02f, 16'h0005}, {17'h0_a030, 16'h000a}});
	endtask
	// Largest count, sent as broadcast
	task automatic t_max();
		bytes_type f;
		logic [32:0] w[$];
		f = '{8'h00, 8'h10, 8'h00, 8'h10, 8'h00, 8'h7d, 8'hfa};
		for (int k = 0; k < 125; k++) begin
			f.push_back(8'(k));
			f.push_back(~8'(k));
			w.push_back({17'h0_9c51 + 17'(k), 8'(k), ~8'(k)});
		end
		setup(8'h05, 1'b0);
		run(f, 1'b0, 1'b0, none, w);
	endtask
	task automatic t_refuse();
		bytes_type c[8];
		c[0] = '{8'h05, 8'h06, 8'h01, 8'h00, 8'h12, 8'h34};
		c[1] = '{8'h07, 8'h06, 8'h00, 8'h0d, 8'h12, 8'h34};
		c[2] = c[0];
		c[2][2] = 8'h00;
		c[3] = c[2];
		c[4] = '{8'h05, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h03, 8'h00, 8'h01, 8'h00};
		c[5] = '{8'h05, 8'h08, 8'h00, 8'h01, 8'h12, 8'h34};
		c[6] = '{8'h05, 8'h10, 8'h00, 8'h00, 8'h00, 8'h7e, 8'hfc};
		for (int k = 0; k < 252; k++)
			c[6].push_back(8'(k));
		// Count with its top bit set still pairs with byte count 4; only the limit refuses it
		c[7] = '{8'h05, 8'h10, 8'h00, 8'h00, 8'h80, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02};
		setup(8'h05, 1'b0);
		for (int i = 0; i < 8; i++)
			run(c[i], i == 2, i == 3, none, nowr);
	endtask
	task automatic wrap_up();
		if (err_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Run cut short well past the expected length
	initial begin
		#(50 * 60000);
		err_count++;
		wrap_up();
	end
	initial begin
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		repeat (3) @(posedge clock);
		t_single();
		t_diag();
		t_multi();
		t_max();
		t_refuse();
		wrap_up();
	end
endmodule // fieldbus_slave_bench
